/* shared/tach_bind_regs.svh */
/*
  register offsets, field positions, reset values and edge codes for the
  tachometer binding and status/control block.
  assumes: included by bare name from the package and the design file.
*/
`ifndef TACH_BIND_REGS_SVH
`define TACH_BIND_REGS_SVH
`define OFS_TACH_PWM_BINDING 8'hE0
`define OFS_STATUS_AND_CONTROL 8'hE2
`define RST_TACH_PWM_BINDING 8'h00
`define RST_STATUS_AND_CONTROL 8'h00
`define RST_CTRL_BITS 6'h00
`define WR_MASK_NONE 8'h00
`define WR_MASK_LOCKABLE 8'h02
`define RD_UNMAPPED 8'h00
`define BIT_OVERRIDE 0
`define BIT_ROR_MODE 1
`define BIT_IN4_AM 2
`define BIT_IN5_AM 3
`define FLD_EDGE_LO 4
`define FLD_EDGE_HI 5
`define BIT_HOST_SUM 6
`define BIT_MGMT_SUM 7
`define BIT_CFG_ALERT_EN 3
`define EDGE_CODE_EITHER 2'h0
`define EDGE_CODE_RISE 2'h1
`define EDGE_CODE_FALL 2'h2
`define EDGE_CODE_RSVD 2'h3
`define WR_MASK_CTRL 8'h3D
`endif

/* shared/tach_bind_pkg.sv */
/*
  types for the tachometer binding and status/control block.
  assumes: the constants header sits beside it on the include path.
*/
`include "tach_bind_regs.svh"
package tach_bind_pkg;
  // edge selection handed to the tachometer measurement logic
  typedef enum logic [1:0]
  {
    EDGE_EITHER = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10
  } tach_edge_t;
endpackage

/* rtl/tach_binding_status.sv */
/*
  tachometer-to-pwm binding register and status/control register.
  assumes: a byte-wide register port from the serial interface decoder with
  one-cycle read and write strobes; error status registers, pwm and tach
  logic live outside and exchange levels with this block.
*/
// Contract
// - one binding bit per tach and pwm
// - bound tach errors masked at zero/spin-up
// - mode bit picks clear-on-read or write-one
// - lock freezes mode bit while cfg_lock is high
// - input4 event masks all other errors
// - status frozen until input4 flag clears
// - edge field selects tach edges
// - host summary reflects any host error
// - mgmt summary drives alert when enabled
// - alert only while alert enable set
// - spin-up window also masks bound tach
`timescale 1ns/1ps
`include "tach_bind_regs.svh"
module tach_binding_status
  import tach_bind_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // configuration levels from elsewhere
  input wire logic cfg_lock,
  input wire logic cfg_alert_en,
  // pwm state
  input wire logic [1:0] pwm_duty_zero,
  input wire logic [1:0] pwm_spinning_up,
  // raw tach errors and error status summaries
  input wire logic [3:0] tach_err_raw,
  input wire logic [3:0] tach_err_masked_n_unused_dummy,
  input wire logic host_any_error,
  input wire logic mgmt_any_error,
  input wire logic host_input4_error_flag,
  input wire logic mgmt_input4_error_flag,
  input wire logic host_input5_error_flag,
  input wire logic mgmt_input5_error_flag,
  // controls to the rest of the device
  output logic [3:0] tach_err_suppress,
  output logic pwm_full_override,
  output logic reset_on_read_mode,
  output tach_edge_t tach_edge_sel,
  output logic mgmt_record_hold,
  output logic host_record_hold,
  output logic alert_n
);

  logic [7:0] binding_q;
  logic [5:0] ctrl_q;
  logic [7:0] binding_d;
  logic [5:0] ctrl_d;
  wire sel_bind = reg_addr == `OFS_TACH_PWM_BINDING;
  wire sel_ctrl = reg_addr == `OFS_STATUS_AND_CONTROL;
  // the lockable mode bit drops out of the write mask while the lock stands
  wire [7:0] wr_mask = `WR_MASK_CTRL | (cfg_lock ? `WR_MASK_NONE : `WR_MASK_LOCKABLE);

  // next values: writes land directly, mode bit guarded by the lock
  assign binding_d = (reg_wr && sel_bind) ? reg_wdata : binding_q;
  assign ctrl_d = (reg_wr && sel_ctrl) ?
    ((reg_wdata[5:0] & wr_mask[5:0]) | (ctrl_q & ~wr_mask[5:0])) : ctrl_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      binding_q <= `RST_TACH_PWM_BINDING;
      ctrl_q <= `RST_CTRL_BITS;
    end
    else
    begin
      binding_q <= binding_d;
      ctrl_q <= ctrl_d;
    end
  end

  // a pwm is quiet while stopped or spinning up; a tach bound to both is undefined, we or the two
  wire [1:0] pwm_quiet = pwm_duty_zero | pwm_spinning_up;
  genvar t;
  generate
    for (t = 0; t < 4; t++)
    begin : g_tach
      assign tach_err_suppress[t] = (binding_q[2*t] & pwm_quiet[0]) | (binding_q[2*t+1] & pwm_quiet[1]);
    end
  endgenerate

  // control outputs
  assign pwm_full_override = ctrl_q[`BIT_OVERRIDE];
  assign reset_on_read_mode = ctrl_q[`BIT_ROR_MODE];
  wire [1:0] edge_code = ctrl_q[`FLD_EDGE_HI:`FLD_EDGE_LO];
  // reserved code falls back to either-edge so measurement keeps running
  assign tach_edge_sel = (edge_code == `EDGE_CODE_RSVD) ? EDGE_EITHER : tach_edge_t'(edge_code);

  // hold for one side: an armed input whose flag still stands freezes recording
  // the hold is a level, so it lifts on its own once the host clears that flag
  function automatic logic hold_of(input logic am4, input logic am5, input logic flag4, input logic flag5);
    hold_of = (am4 & flag4) | (am5 & flag5);
  endfunction

  // auto-mask: status logic stops recording new events while the flag stands
  // each side keys on its own flag, so host and management release separately
  assign mgmt_record_hold = hold_of(ctrl_q[`BIT_IN4_AM], ctrl_q[`BIT_IN5_AM],
    mgmt_input4_error_flag, mgmt_input5_error_flag);
  assign host_record_hold = hold_of(ctrl_q[`BIT_IN4_AM], ctrl_q[`BIT_IN5_AM],
    host_input4_error_flag, host_input5_error_flag);

  // summaries are pure combinational views, no write needed to drop them
  wire [7:0] ctrl_view = {mgmt_any_error, host_any_error, ctrl_q};
  assign alert_n = ~(mgmt_any_error & cfg_alert_en);

  // read mux: unmapped addresses return zero
  // no read side effects: clear-on-read is done by the status registers outside
  assign reg_rdata = sel_bind ? binding_q : (sel_ctrl ? ctrl_view : `RD_UNMAPPED);

  a_bind_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && sel_bind |=> binding_q == $past(reg_wdata)) else $error("binding write lost");
  a_mask_quiet: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[0] && pwm_duty_zero[0] |-> tach_err_suppress[0]) else $error("tach1 not masked");
  a_spin_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[7] && pwm_spinning_up[1] |-> tach_err_suppress[3]) else $error("tach4 spin not masked");
  a_no_false_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q == `RST_TACH_PWM_BINDING |-> tach_err_suppress == 4'h0) else $error("unbound tach masked");
  a_override_full: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && sel_ctrl && reg_wdata[0] |=> pwm_full_override) else $error("override not set");
  a_lock_holds: assert property (@(posedge core_clk) disable iff (rst)
    cfg_lock && reg_wr && sel_ctrl |=> $stable(reset_on_read_mode)) else $error("locked bit changed");
  a_unlock_mode: assert property (@(posedge core_clk) disable iff (rst)
    !cfg_lock && reg_wr && sel_ctrl |=> reset_on_read_mode == $past(reg_wdata[1])) else $error("mode bit lost");
  a_hold_in4: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[2] && mgmt_input4_error_flag |-> mgmt_record_hold) else $error("auto-mask missing");
  a_hold_in5: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[3] && host_input5_error_flag |-> host_record_hold) else $error("input5 mask missing");
  a_edge_rsvd: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[5:4] == 2'h3 |-> tach_edge_sel == EDGE_EITHER) else $error("reserved edge");
  a_alert_gate: assert property (@(posedge core_clk) disable iff (rst)
    !alert_n |-> cfg_alert_en && mgmt_any_error) else $error("alert without cause");
  a_summary_view: assert property (@(posedge core_clk) disable iff (rst)
    sel_ctrl |-> reg_rdata[7:6] == {mgmt_any_error, host_any_error}) else $error("summary wrong");


  // multi-step checks start from one of these accepted writes
  sequence s_ctrl_write;
    reg_wr && sel_ctrl;
  endsequence

  sequence s_bind_write;
    reg_wr && sel_bind;
  endsequence

  // every remaining tach and pwm pair masks its channel while that pwm is quiet
  a_t1_pwm2_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[1] && pwm_quiet[1] |-> tach_err_suppress[0]) else $error("tach1 pwm2 not masked");

  a_t2_pwm1_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[2] && pwm_quiet[0] |-> tach_err_suppress[1]) else $error("tach2 pwm1 not masked");

  a_t2_pwm2_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[3] && pwm_quiet[1] |-> tach_err_suppress[1]) else $error("tach2 pwm2 not masked");

  a_t3_pwm1_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[4] && pwm_quiet[0] |-> tach_err_suppress[2]) else $error("tach3 pwm1 not masked");

  a_t3_pwm2_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[5] && pwm_quiet[1] |-> tach_err_suppress[2]) else $error("tach3 pwm2 not masked");

  a_t4_pwm1_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[6] && pwm_quiet[0] |-> tach_err_suppress[3]) else $error("tach4 pwm1 not masked");

  a_t4_zero_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[7] && pwm_duty_zero[1] |-> tach_err_suppress[3]) else $error("tach4 zero not masked");

  a_t1_spin_mask: assert property (@(posedge core_clk) disable iff (rst)
    binding_q[0] && pwm_spinning_up[0] |-> tach_err_suppress[0]) else $error("tach1 spin not masked");

  // a running fan must never hide its tach errors
  a_busy_no_mask: assert property (@(posedge core_clk) disable iff (rst)
    pwm_duty_zero == 2'b00 && pwm_spinning_up == 2'b00 |-> tach_err_suppress == 4'h0)
    else $error("running pwm masked");

  // register contents move only on an accepted write
  a_bind_stable: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && sel_bind) |=> $stable(binding_q)) else $error("binding changed unwritten");

  a_ctrl_stable: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && sel_ctrl) |=> $stable(ctrl_q)) else $error("control changed unwritten");

  a_bind_apply: assert property (@(posedge core_clk) disable iff (rst)
    s_bind_write |=> reg_rdata == $past(reg_wdata) || !sel_bind) else $error("binding readback");

  a_override_off: assert property (@(posedge core_clk) disable iff (rst)
    s_ctrl_write ##0 !reg_wdata[`BIT_OVERRIDE] |=> !pwm_full_override) else $error("override stuck");

  a_am_write: assert property (@(posedge core_clk) disable iff (rst)
    s_ctrl_write |=> ctrl_q[`BIT_IN5_AM:`BIT_IN4_AM] == $past(reg_wdata[3:2])) else $error("auto-mask bits lost");

  a_edge_write: assert property (@(posedge core_clk) disable iff (rst)
    s_ctrl_write ##0 reg_wdata[5:4] != 2'h3 |=> tach_edge_sel == tach_edge_t'($past(reg_wdata[5:4])))
    else $error("edge code lost");

  // hold and alert levels
  a_host_hold4: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[`BIT_IN4_AM] && host_input4_error_flag |-> host_record_hold) else $error("host hold missing");

  a_mgmt_hold5: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_q[`BIT_IN5_AM] && mgmt_input5_error_flag |-> mgmt_record_hold) else $error("mgmt input5 hold missing");

  a_hold_release: assert property (@(posedge core_clk) disable iff (rst)
    !mgmt_input4_error_flag && !mgmt_input5_error_flag |-> !mgmt_record_hold) else $error("hold not released");

  a_alert_idle: assert property (@(posedge core_clk) disable iff (rst)
    !cfg_alert_en |-> alert_n) else $error("alert while disabled");

  a_alert_fire: assert property (@(posedge core_clk) disable iff (rst)
    cfg_alert_en && mgmt_any_error |-> !alert_n) else $error("alert missing");

  // read view of mode bit and unmapped addresses
  a_mode_view: assert property (@(posedge core_clk) disable iff (rst)
    sel_ctrl |-> reg_rdata[`BIT_ROR_MODE] == reset_on_read_mode) else $error("mode readback");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
    !sel_bind && !sel_ctrl |-> reg_rdata == `RD_UNMAPPED) else $error("unmapped read not zero");

endmodule

/* test/err_status_model.sv */
/*
  far-side model of one external error status register.
  assumes: the bench drives events on core_clk; clr acts as a write-one clear.
*/
`timescale 1ns/1ps
module err_status_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // events and controls
  input wire logic ev_in4,
  input wire logic ev_other,
  input wire logic hold,
  input wire logic clr,
  // recorded flags
  output logic in4_q,
  output logic other_q
);
  // other events are dropped while recording is held
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      {in4_q, other_q} <= 2'b00;
    else if (clr)
      {in4_q, other_q} <= 2'b00;
    else
      {in4_q, other_q} <= {in4_q | ev_in4, other_q | (ev_other & ~hold)};
endmodule

/* test/tach_binding_status_tb_top.sv */
/*
  bench for the binding and status/control registers.
  assumes: package and error status model are compiled first.
*/
`timescale 1ns/1ps
module tach_binding_status_tb_top import tach_bind_pkg::*;;
  logic core_clk = 0, rst = 1, reg_wr = 0, cfg_lock = 0, alert_en = 0;
  logic ev4 = 0, evo = 0, clr = 0, m_in4, m_oth, h_any = 0, h4 = 0, h5 = 0, m5 = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [1:0] dz = 0, su = 0;
  logic [3:0] supp;
  logic ovr, ror, mhold, hhold, alert_n;
  tach_edge_t edge_sel;
  int fails = 0, checks_done = 0;
  tach_binding_status tach_binding_status_i (.core_clk(core_clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_rd(1'b0), .reg_wdata(wdata), .reg_rdata(rdata), .cfg_lock(cfg_lock), .cfg_alert_en(alert_en),
    .pwm_duty_zero(dz), .pwm_spinning_up(su), .tach_err_raw(4'h0), .tach_err_masked_n_unused_dummy(4'h0),
    .host_any_error(h_any), .mgmt_any_error(m_in4 | m_oth), .host_input4_error_flag(h4),
    .mgmt_input4_error_flag(m_in4), .host_input5_error_flag(h5), .mgmt_input5_error_flag(m5),
    .tach_err_suppress(supp), .pwm_full_override(ovr), .reset_on_read_mode(ror), .tach_edge_sel(edge_sel),
    .mgmt_record_hold(mhold), .host_record_hold(hhold), .alert_n(alert_n));
  err_status_model err_status_model_i (.core_clk(core_clk), .rst(rst), .ev_in4(ev4), .ev_other(evo),
    .hold(mhold), .clr(clr), .in4_q(m_in4), .other_q(m_oth));
  always #50 core_clk = ~core_clk;
  task automatic tick();
    @(posedge core_clk);
    #5;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    addr = a;
    wdata = d;
    reg_wr = 1;
    tick();
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick();
    addr = a;
    tick();
    chk(rdata, e);
  endtask
  task automatic end_sim();
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    fails++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    #5;
    rst = 0;
    rd(8'hE2, 8'h00);
    wr(8'hE0, 8'h61);
    wr(8'hE1, 8'hFF);
    rd(8'hE0, 8'h61);
    rd(8'hE1, 8'h00);
    dz = 2'b01;
    tick();
    chk({4'h0, supp}, 8'h09);
    dz = 2'b00;
    su = 2'b10;
    tick();
    chk({4'h0, supp}, 8'h04);
    su = 2'b00;
    tick();
    chk({4'h0, supp}, 8'h00);
    wr(8'hE2, 8'hFF);
    rd(8'hE2, 8'h3F);
    chk({5'h00, ovr, ror, edge_sel}, 8'h0C);
    for (int c = 0; c < 3; c++)
    begin
      wr(8'hE2, 8'(c << 4));
      chk({6'h00, edge_sel}, 8'(c));
    end
    wr(8'hE2, 8'h02);
    cfg_lock = 1;
    wr(8'hE2, 8'h01);
    chk({6'h00, ovr, ror}, 8'h03);
    cfg_lock = 0;
    wr(8'hE2, 8'h00);
    chk({7'h00, ror}, 8'h00);
    h_any = 1;
    rd(8'hE2, 8'h40);
    h_any = 0;
    evo = 1;
    tick();
    evo = 0;
    rd(8'hE2, 8'h80);
    chk({7'h00, alert_n}, 8'h01);
    alert_en = 1;
    tick();
    chk({7'h00, alert_n}, 8'h00);
    clr = 1;
    tick();
    clr = 0;
    rd(8'hE2, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    wr(8'hE2, 8'h04);
    ev4 = 1;
    tick();
    ev4 = 0;
    evo = 1;
    h4 = 1;
    tick();
    evo = 0;
    chk({5'h00, mhold, hhold, m_oth}, 8'h06);
    clr = 1;
    h4 = 0;
    tick();
    clr = 0;
    evo = 1;
    tick();
    evo = 0;
    chk({5'h00, mhold, hhold, m_oth}, 8'h01);
    clr = 1;
    tick();
    clr = 0;
    wr(8'hE2, 8'h08);
    m5 = 1;
    h5 = 1;
    tick();
    chk({6'h00, mhold, hhold}, 8'h03);
    end_sim();
  end
endmodule
